// ---- common/asp_defs.svh ----
// Constants of the async serial port: register offsets, field positions, reset values, timing.
// Assumes inclusion by the package and the modules; definitions only.
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ******************************
// Register offsets (byte addresses)
// ******************************
`define ASP_OFS_DATA    4'h0
`define ASP_OFS_INT_EN  4'h1
`define ASP_OFS_INT_ID  4'h2
`define ASP_OFS_LCR     4'h3
`define ASP_OFS_MCR     4'h4
`define ASP_OFS_LSR     4'h5
`define ASP_OFS_MSR     4'h6
`define ASP_OFS_DIV     4'h7
`define ASP_OFS_STAT    4'h8
`define ASP_OFS_CLR     4'h9
`define ASP_OFS_SRST    4'ha
`define ASP_OFS_SHADOW  4'hb

// ******************************
// Line control fields
// ******************************
`define ASP_LCR_WLEN_LO   0
`define ASP_LCR_STOP      2
`define ASP_LCR_PEN       3
`define ASP_LCR_EPS       4
`define ASP_LCR_BREAK     6
`define ASP_LCR_RESET     8'h03

// ******************************
// Modem control fields
// ******************************
`define ASP_MCR_DTR       0
`define ASP_MCR_RTS       1
`define ASP_MCR_AFC       5
`define ASP_MCR_SIR       6
`define ASP_MCR_SIR_LP    7
`define ASP_MCR_RESET     8'h00

// ******************************
// Interrupt status bits and identification codes
// ******************************
`define ASP_IRQ_RLS       0
`define ASP_IRQ_RDA       1
`define ASP_IRQ_TX_HOLDING_EMPTY 2
`define ASP_IRQ_MSR       3
`define ASP_IID_NONE      4'h1
`define ASP_IID_RLS       4'h6
`define ASP_IID_RDA       4'h4
`define ASP_IID_TX_HOLDING_EMPTY 4'h2
`define ASP_IID_MSR       4'h0

// ******************************
// Defaults and timing
// ******************************
`define ASP_DIV_RESET     16'h0001
`define ASP_FIFO_DEPTH    16
`define ASP_OVERSAMPLE    16
`define ASP_SIR_PULSE     3
`define ASP_SIR_LP_PULSE  1
`define ASP_SRST_KEY      8'ha5

`endif

// ---- common/asp_pkg.sv ----
// Types of the async serial port.
// Assumes the defines header sits beside it.
package asp_pkg;
	typedef enum logic [2:0] {ASP_TX_IDLE, ASP_TX_START, ASP_TX_DATA, ASP_TX_PAR, ASP_TX_STOP}
		asp_tx_state_t;
	typedef enum logic [2:0] {ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_PAR, ASP_RX_STOP}
		asp_rx_state_t;
endpackage

// ---- common/asp_fifo_if.sv ----
// Push and pop bundle between the serial port core and its byte FIFOs.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ns
interface asp_fifo_if #(parameter int WIDTH = 8, parameter int CNTW = 5);
	logic push;
	logic [WIDTH-1:0] wdata;
	logic pop;
	logic [WIDTH-1:0] rdata;
	logic full;
	logic empty;
	logic [CNTW-1:0] count;
	modport core (output push, output wdata, output pop, input rdata, input full, input empty,
		input count);
	modport store (input push, input wdata, input pop, output rdata, output full, output empty,
		output count);
endinterface

// ---- rtl/asp_fifo.sv ----
// Byte FIFO with a registered head output and a flush input.
// Assumes pushes when full and pops when empty are ignored.
`timescale 1ns/1ns
module asp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int CNTW = 5
) (
	// Clock and resets.
	input wire logic core_clk,
	input wire logic reset,
	input wire logic flush,
	// Port towards the core.
	asp_fifo_if.store f
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [CNTW-1:0] cnt_r, cnt_nxt;
	logic [WIDTH-1:0] head_r;
	logic do_push, do_pop;

	// Pointer and count arithmetic; a flush empties without touching storage.
	always_comb begin
		do_push = f.push && (cnt_r != CNTW'(DEPTH));
		do_pop = f.pop && (cnt_r != '0);
		wp_nxt = do_push ? wp_r + AW'(1) : wp_r;
		rp_nxt = do_pop ? rp_r + AW'(1) : rp_r;
		cnt_nxt = cnt_r + CNTW'(do_push) - CNTW'(do_pop);
		if (flush) begin
			wp_nxt = '0;
			rp_nxt = '0;
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage and registered head; the head tracks the next read pointer.
	always_ff @(posedge core_clk) begin
		if (do_push)
			mem[wp_r] <= f.wdata;
		head_r <= (do_push && wp_r == rp_nxt) ? f.wdata : mem[rp_nxt];
	end

	assign f.rdata = head_r;
	assign f.full = (cnt_r == CNTW'(DEPTH));
	assign f.empty = (cnt_r == '0);
	assign f.count = cnt_r;
endmodule // asp_fifo

// ---- rtl/asp_baud.sv ----
// Baud tick generator: one pulse per sixteenth of a bit.
// Assumes a divisor of zero stalls the ticks.
`timescale 1ns/1ns
module asp_baud #(
	parameter int DW = 16
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset,
	// Control.
	input wire logic [DW-1:0] divisor,
	output logic tick
);
	logic [DW-1:0] cnt_r, cnt_nxt;
	logic tick_nxt;

	// Count down the divisor; each wrap gives one oversample tick.
	always_comb begin
		tick_nxt = 1'b0;
		cnt_nxt = cnt_r - DW'(1);
		if (divisor == '0) begin
			cnt_nxt = '0;
		end else if (cnt_r <= DW'(1)) begin
			cnt_nxt = divisor;
			tick_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick <= tick_nxt;
		end
	end
endmodule // asp_baud

// ---- rtl/asp_uart.sv ----
// Async serial port core: register file, transmitter, receiver, interrupts.
// Assumes rx, cts and dsr pins are asynchronous and a 10 MHz core_clk.
`timescale 1ns/1ns
`include "asp_defs.svh"

// ******************************
// Top module
// ******************************
module asp_uart
	import asp_pkg::*;
#(
	parameter int DEPTH = `ASP_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic reset,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Serial and modem pins.
	output logic txd,
	input wire logic rxd,
	output logic rts_n,
	input wire logic cts_n,
	output logic dtr_n,
	input wire logic dsr_n,
	// Interrupt.
	output logic irq
);
	localparam int CW = $clog2(DEPTH) + 1;
	logic srst;
	logic tick;

	// ******************************
	// Registers and soft reset
	// ******************************
	logic [7:0] lcr_r, lcr_nxt, mcr_r, mcr_nxt;
	logic [15:0] div_r, div_nxt;
	logic [3:0] ien_r, ien_nxt, stat_r, stat_nxt;
	logic [1:0] rstat_r, rstat_nxt; // Sticky overrun, sticky error.
	logic srst_r, srst_nxt;
	logic [15:0] rdata_nxt;
	logic [3:0] iid;
	logic [3:0] ev;
	logic ovr_ev, err_ev, tx_holding_empty_ev, msr_ev;
	logic [1:0] msr_sync1_r, msr_sync2_r, msr_prev_r;

	asp_fifo_if #(.WIDTH(8), .CNTW(CW)) txf ();
	asp_fifo_if #(.WIDTH(11), .CNTW(CW)) rxf ();

	asp_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CNTW(CW)) u_txf (
		.core_clk(core_clk), .reset(reset), .flush(srst), .f(txf.store));
	asp_fifo #(.WIDTH(11), .DEPTH(DEPTH), .CNTW(CW)) u_rxf (
		.core_clk(core_clk), .reset(reset), .flush(srst), .f(rxf.store));
	asp_baud #(.DW(16)) u_baud (.core_clk(core_clk), .reset(reset), .divisor(div_r),
		.tick(tick));

	assign srst = srst_r;
	// Highest priority first: line status, data, transmit empty, modem.
	always_comb begin
		if (stat_r[`ASP_IRQ_RLS] && ien_r[`ASP_IRQ_RLS]) iid = `ASP_IID_RLS;
		else if (stat_r[`ASP_IRQ_RDA] && ien_r[`ASP_IRQ_RDA]) iid = `ASP_IID_RDA;
		else if (stat_r[`ASP_IRQ_TX_HOLDING_EMPTY] && ien_r[`ASP_IRQ_TX_HOLDING_EMPTY])
			iid = `ASP_IID_TX_HOLDING_EMPTY;
		else if (stat_r[`ASP_IRQ_MSR] && ien_r[`ASP_IRQ_MSR]) iid = `ASP_IID_MSR;
		else iid = `ASP_IID_NONE;
	end

	// Register writes, reads, sticky status; an event in a clear cycle wins.
	always_comb begin
		lcr_nxt = lcr_r;
		mcr_nxt = mcr_r;
		div_nxt = div_r;
		ien_nxt = ien_r;
		srst_nxt = 1'b0;
		rdata_nxt = 16'h0000;
		txf.push = 1'b0;
		txf.wdata = reg_wdata[7:0];
		rxf.pop = 1'b0;
		stat_nxt = stat_r;
		rstat_nxt = rstat_r;
		ev = {msr_ev, tx_holding_empty_ev, !rxf.empty, ovr_ev | err_ev};
		if (reg_wr) begin
			case (reg_addr)
				`ASP_OFS_DATA: txf.push = 1'b1;
				`ASP_OFS_INT_EN: ien_nxt = reg_wdata[3:0];
				`ASP_OFS_LCR: lcr_nxt = reg_wdata[7:0];
				`ASP_OFS_MCR: mcr_nxt = reg_wdata[7:0];
				`ASP_OFS_DIV: div_nxt = reg_wdata;
				`ASP_OFS_CLR: begin
					stat_nxt = stat_r & ~reg_wdata[3:0];
					if (reg_wdata[`ASP_IRQ_RLS]) rstat_nxt = 2'b00;
				end
				`ASP_OFS_SRST: srst_nxt = (reg_wdata[7:0] == `ASP_SRST_KEY);
				`ASP_OFS_SHADOW: begin
					// Shadow alias writes the DTR and RTS bits of modem control without read-modify-write.
					mcr_nxt[`ASP_MCR_RTS] = reg_wdata[`ASP_MCR_RTS];
					mcr_nxt[`ASP_MCR_DTR] = reg_wdata[`ASP_MCR_DTR];
				end
				default: ;
			endcase
		end
		stat_nxt = stat_nxt | ev;
		rstat_nxt = rstat_nxt | {ovr_ev, err_ev};
		if (reg_rd) begin
			case (reg_addr)
				`ASP_OFS_DATA: begin
					rdata_nxt = {5'h00, rxf.rdata};
					rxf.pop = 1'b1;
				end
				`ASP_OFS_INT_EN: rdata_nxt = {12'h000, ien_r};
				`ASP_OFS_INT_ID: rdata_nxt = {12'h000, iid};
				`ASP_OFS_LCR: rdata_nxt = {8'h00, lcr_r};
				`ASP_OFS_MCR: rdata_nxt = {8'h00, mcr_r};
				`ASP_OFS_LSR: rdata_nxt = {8'h00, txf.empty, txf.full, rstat_r, rxf.full,
					1'b0, rxf.empty, !rxf.empty};
				`ASP_OFS_MSR: rdata_nxt = {14'h0000, msr_sync2_r};
				`ASP_OFS_DIV: rdata_nxt = div_r;
				`ASP_OFS_STAT: rdata_nxt = {12'h000, stat_r};
				`ASP_OFS_SHADOW: rdata_nxt = {3'h0, rxf.count, 3'h0, txf.count};
				default: rdata_nxt = 16'h0000;
			endcase
		end
		if (srst_r) begin
			lcr_nxt = `ASP_LCR_RESET;
			mcr_nxt = `ASP_MCR_RESET;
			div_nxt = `ASP_DIV_RESET;
			ien_nxt = 4'h0;
			stat_nxt = 4'h0;
			rstat_nxt = 2'b00;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lcr_r <= `ASP_LCR_RESET;
			mcr_r <= `ASP_MCR_RESET;
			div_r <= `ASP_DIV_RESET;
			ien_r <= 4'h0;
			stat_r <= 4'h0;
			rstat_r <= 2'b00;
			srst_r <= 1'b0;
			reg_rdata <= 16'h0000;
			irq <= 1'b0;
		end else begin
			lcr_r <= lcr_nxt;
			mcr_r <= mcr_nxt;
			div_r <= div_nxt;
			ien_r <= ien_nxt;
			stat_r <= stat_nxt;
			rstat_r <= rstat_nxt;
			srst_r <= srst_nxt;
			reg_rdata <= rdata_nxt;
			irq <= |(stat_nxt & ien_nxt);
		end
	end

	// ******************************
	// Pin synchronisers and modem change detect
	// ******************************
	logic rx_s1_r, rx_s2_r;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_s1_r <= 1'b1;
			rx_s2_r <= 1'b1;
			msr_sync1_r <= 2'b00;
			msr_sync2_r <= 2'b00;
			msr_prev_r <= 2'b00;
		end else begin
			rx_s1_r <= rxd;
			rx_s2_r <= rx_s1_r;
			msr_sync1_r <= {~dsr_n, ~cts_n};
			msr_sync2_r <= msr_sync1_r;
			msr_prev_r <= msr_sync2_r;
		end
	end
	assign msr_ev = (msr_sync2_r != msr_prev_r);

	// ******************************
	// Transmitter
	// ******************************
	asp_tx_state_t tx_st_r, tx_st_nxt;
	logic [7:0] tx_sh_r, tx_sh_nxt;
	logic [3:0] tx_os_r, tx_os_nxt;
	logic [2:0] tx_bit_r, tx_bit_nxt;
	logic [1:0] tx_half_r, tx_half_nxt;
	logic tx_par_r, tx_par_nxt, tx_line;
	logic [2:0] nbits;
	logic [1:0] stop_halves;
	logic tx_go, tx_empty_prev_r;
	logic [3:0] pulse_len;
	logic txd_nxt, rts_nxt;

	assign nbits = {1'b1, lcr_r[1:0]};
	// Stop length in half bits, minus one: 1 bit, 1.5 for 5-bit chars, else 2.
	assign stop_halves = !lcr_r[`ASP_LCR_STOP] ? 2'd1 : (lcr_r[1:0] == 2'b00 ? 2'd2 : 2'd3);
	assign tx_go = !txf.empty && (!mcr_r[`ASP_MCR_AFC] || msr_sync2_r[0]);
	assign tx_holding_empty_ev = txf.empty && !tx_empty_prev_r;

	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_sh_nxt = tx_sh_r;
		tx_os_nxt = tx_os_r;
		tx_bit_nxt = tx_bit_r;
		tx_half_nxt = tx_half_r;
		tx_par_nxt = tx_par_r;
		txf.pop = 1'b0;
		tx_line = 1'b1;
		case (tx_st_r)
			ASP_TX_IDLE: begin
				if (tx_go && tick) begin
					txf.pop = 1'b1;
					tx_sh_nxt = txf.rdata;
					tx_par_nxt = ~lcr_r[`ASP_LCR_EPS];
					tx_os_nxt = 4'h0;
					tx_st_nxt = ASP_TX_START;
				end
			end
			ASP_TX_START: begin
				tx_line = 1'b0;
				if (tick) begin
					tx_os_nxt = tx_os_r + 4'h1;
					if (tx_os_r == 4'hf) begin
						tx_bit_nxt = 3'd0;
						tx_st_nxt = ASP_TX_DATA;
					end
				end
			end
			ASP_TX_DATA: begin
				tx_line = tx_sh_r[0];
				if (tick) begin
					tx_os_nxt = tx_os_r + 4'h1;
					if (tx_os_r == 4'hf) begin
						tx_par_nxt = tx_par_r ^ tx_sh_r[0];
						tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
						tx_bit_nxt = tx_bit_r + 3'd1;
						tx_half_nxt = 2'd0;
						if (tx_bit_r == nbits)
							tx_st_nxt = lcr_r[`ASP_LCR_PEN] ? ASP_TX_PAR : ASP_TX_STOP;
					end
				end
			end
			ASP_TX_PAR: begin
				tx_line = tx_par_r;
				if (tick) begin
					tx_os_nxt = tx_os_r + 4'h1;
					if (tx_os_r == 4'hf) tx_st_nxt = ASP_TX_STOP;
				end
			end
			ASP_TX_STOP: begin
				if (tick) begin
					tx_os_nxt = {1'b0, tx_os_r[2:0] + 3'd1};
					if (tx_os_r[2:0] == 3'h7) begin
						tx_half_nxt = tx_half_r + 2'd1;
						tx_os_nxt = 4'h0;
						if (tx_half_r == stop_halves) tx_st_nxt = ASP_TX_IDLE;
					end
				end
			end
			default: tx_st_nxt = ASP_TX_IDLE;
		endcase
		if (lcr_r[`ASP_LCR_BREAK]) tx_line = 1'b0;
		// SIR sends a short high pulse at the start of each zero bit, idle low.
		pulse_len = mcr_r[`ASP_MCR_SIR_LP] ? 4'(`ASP_SIR_LP_PULSE) : 4'(`ASP_SIR_PULSE);
		if (mcr_r[`ASP_MCR_SIR])
			txd_nxt = !tx_line && (tx_os_r < pulse_len);
		else
			txd_nxt = tx_line;
		// Request to send stays asserted while there is room for three more bytes.
		rts_nxt = !(mcr_r[`ASP_MCR_RTS] &&
			(!mcr_r[`ASP_MCR_AFC] || rxf.count < CW'(DEPTH - 2)));
		if (srst_r) tx_st_nxt = ASP_TX_IDLE;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_st_r <= ASP_TX_IDLE;
			tx_sh_r <= 8'h00;
			tx_os_r <= 4'h0;
			tx_bit_r <= 3'd0;
			tx_half_r <= 2'd0;
			tx_par_r <= 1'b0;
			tx_empty_prev_r <= 1'b1;
			txd <= 1'b1;
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_os_r <= tx_os_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_half_r <= tx_half_nxt;
			tx_par_r <= tx_par_nxt;
			tx_empty_prev_r <= txf.empty;
			txd <= txd_nxt;
			rts_n <= rts_nxt;
			dtr_n <= !mcr_r[`ASP_MCR_DTR];
		end
	end

	// ******************************
	// Receiver
	// ******************************
	asp_rx_state_t rx_st_r, rx_st_nxt;
	logic [7:0] rx_sh_r, rx_sh_nxt;
	logic [3:0] rx_os_r, rx_os_nxt;
	logic [2:0] rx_bit_r, rx_bit_nxt;
	logic rx_perr_r, rx_perr_nxt, rx_line;

	// SIR receive: a high pulse marks a zero bit; the idle line reads high.
	assign rx_line = mcr_r[`ASP_MCR_SIR] ? !rx_s2_r : rx_s2_r;

	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sh_nxt = rx_sh_r;
		rx_os_nxt = rx_os_r;
		rx_bit_nxt = rx_bit_r;
		rx_perr_nxt = rx_perr_r;
		rxf.push = 1'b0;
		rxf.wdata = 11'h000;
		ovr_ev = 1'b0;
		err_ev = 1'b0;
		if (tick) begin
			rx_os_nxt = rx_os_r + 4'h1;
			case (rx_st_r)
				ASP_RX_IDLE: begin
					rx_os_nxt = 4'h0;
					if (!rx_line) rx_st_nxt = ASP_RX_START;
				end
				ASP_RX_START: begin
					if (rx_os_r == 4'h7) begin
						rx_os_nxt = 4'h0;
						rx_bit_nxt = 3'd0;
						rx_sh_nxt = 8'h00;
						rx_perr_nxt = lcr_r[`ASP_LCR_EPS];
						rx_st_nxt = rx_line ? ASP_RX_IDLE : ASP_RX_DATA;
					end
				end
				ASP_RX_DATA: begin
					if (rx_os_r == 4'hf) begin
						rx_sh_nxt = {rx_line, rx_sh_r[7:1]};
						rx_perr_nxt = rx_perr_r ^ rx_line;
						rx_bit_nxt = rx_bit_r + 3'd1;
						if (rx_bit_r == nbits)
							rx_st_nxt = lcr_r[`ASP_LCR_PEN] ? ASP_RX_PAR : ASP_RX_STOP;
					end
				end
				ASP_RX_PAR: begin
					if (rx_os_r == 4'hf) begin
						rx_perr_nxt = !(rx_perr_r ^ rx_line);
						rx_st_nxt = ASP_RX_STOP;
					end
				end
				ASP_RX_STOP: begin
					if (rx_os_r == 4'hf) begin
						// Entry: {break, framing, parity, byte right aligned}.
						rxf.wdata = {(rx_sh_r == 8'h00) && !rx_line, !rx_line,
							rx_perr_r && lcr_r[`ASP_LCR_PEN],
							rx_sh_r >> (3'd7 - nbits)};
						rxf.push = 1'b1;
						ovr_ev = rxf.full;
						err_ev = !rx_line || (rx_perr_r && lcr_r[`ASP_LCR_PEN]);
						rx_st_nxt = ASP_RX_IDLE;
					end
				end
				default: rx_st_nxt = ASP_RX_IDLE;
			endcase
		end
		if (srst_r) rx_st_nxt = ASP_RX_IDLE;
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_st_r <= ASP_RX_IDLE;
			rx_sh_r <= 8'h00;
			rx_os_r <= 4'h0;
			rx_bit_r <= 3'd0;
			rx_perr_r <= 1'b0;
		end else begin
			rx_st_r <= rx_st_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_os_r <= rx_os_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_perr_r <= rx_perr_nxt;
		end
	end

	// ******************************
	// Checks
	// ******************************
	a_irq_follows_status: assert property (@(posedge core_clk) disable iff (reset)
		##1 irq == $past(|(stat_nxt & ien_nxt))) else $error("irq mismatch");
	a_rls_top_priority: assert property (@(posedge core_clk) disable iff (reset)
		(stat_r[0] && ien_r[0]) |-> iid == `ASP_IID_RLS) else $error("bad priority");
	a_overrun_sticky: assert property (@(posedge core_clk) disable iff (reset)
		ovr_ev && !srst_r |=> rstat_r[1]) else $error("overrun lost");
	a_break_line_low: assert property (@(posedge core_clk) disable iff (reset)
		lcr_r[6] && !mcr_r[6] |=> !txd) else $error("break not sent");
	a_soft_reset_clears: assert property (@(posedge core_clk) disable iff (reset)
		srst_r |=> lcr_r == `ASP_LCR_RESET && stat_r == 4'h0) else $error("soft reset");
	a_push_to_fifo: assert property (@(posedge core_clk) disable iff (reset)
		reg_wr && reg_addr == `ASP_OFS_DATA && !txf.full && !srst_r |=> !txf.empty)
		else $error("tx push lost");
	a_start_bit_low: assert property (@(posedge core_clk) disable iff (reset)
		tx_st_r == ASP_TX_START && !mcr_r[6] |=> !txd) else $error("start not low");
	a_flow_hold: assert property (@(posedge core_clk) disable iff (reset)
		tx_st_r == ASP_TX_IDLE && mcr_r[5] && !msr_sync2_r[0] |=> tx_st_r == ASP_TX_IDLE)
		else $error("sent against cts");
endmodule // asp_uart

// ---- verification/asp_remote.sv ----
// Far-side serial device: sends characters to the port and decodes the characters it sends.
// Assumes the port's clock is shared, so bit times are whole numbers of core_clk cycles.
`timescale 1ns/1ns
module asp_remote (
	// Clock.
	input wire logic core_clk,
	// Serial and modem pins.
	input wire logic txd,
	output logic rxd,
	input wire logic rts_n,
	output logic cts_n,
	output logic dsr_n
);
	int bitc = 16;
	int nbits = 8;
	bit par_en = 1'b0;
	bit even = 1'b0;
	bit listen = 1'b1;
	bit cts_on = 1'b1;
	bit ignore_rts = 1'b0;
	logic [9:0] got_q[$];
	time stamp_q[$];

	// ******************************
	// Line helpers
	// ******************************
	// Sampling one step after the edge keeps clear of the port's own register updates.
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic put(input logic b);
		rxd <= b;
		repeat (bitc) @(posedge core_clk);
	endtask

	// Sends one character; a scenario may ask for a wrong parity or a low stop bit.
	task automatic send(input logic [7:0] d, input int nb, input bit pe, input bit ev,
		input bit bad_par, input bit low_stop);
		int w;
		logic p;
		w = 0;
		p = 1'b0;
		while (!ignore_rts && rts_n !== 1'b0 && w < 5000) begin
			@(posedge core_clk);
			w++;
		end
		@(posedge core_clk);
		put(1'b0);
		for (int i = 0; i < nb; i++) begin
			put(d[i]);
			p = p ^ d[i];
		end
		if (pe) begin
			put(p ^ !ev ^ bad_par);
		end
		if (low_stop) begin
			put(1'b0);
		end
		put(1'b1);
	endtask

	// Holds the line low for n cycles, then idles it for two bit times.
	task automatic brk(input int n);
		@(posedge core_clk);
		rxd <= 1'b0;
		repeat (n) @(posedge core_clk);
		put(1'b1);
		put(1'b1);
	endtask

	// ******************************
	// Modem lines
	// ******************************
	// Data set ready stays asserted; clear to send follows the scenario.
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
		dsr_n = 1'b0;
	end
	always @(posedge core_clk) begin
		cts_n <= !cts_on;
	end

	// ******************************
	// Decoder of the port's output
	// ******************************
	// Mid-bit sampling tolerates a few cycles of skew between the two ends.
	always begin : rx_dec
		logic [7:0] d;
		logic p;
		logic perr;
		@(negedge txd);
		if (listen) begin
			stamp_q.push_back($time);
			wait_cyc(bitc / 2);
			d = 8'h00;
			p = 1'b0;
			for (int i = 0; i < nbits; i++) begin
				wait_cyc(bitc);
				d[i] = txd;
				p = p ^ txd;
			end
			perr = 1'b0;
			if (par_en) begin
				wait_cyc(bitc);
				perr = (p ^ txd) !== !even;
			end
			wait_cyc(bitc);
			got_q.push_back({txd !== 1'b1, perr, d});
		end
	end
endmodule // asp_remote

// ---- verification/async_serial_port_with_fifos_bench.sv ----
// Self-checking bench of the async serial port, driven through its register port.
// Assumes asp_remote as the far-side device; register offsets are written as numbers.
`timescale 1ns/1ns
module async_serial_port_with_fifos_bench;
	logic core_clk, reset, reg_wr, reg_rd, txd, rxd, rts_n, cts_n, dtr_n, dsr_n, irq;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v, lcv;
	int n_errors = 0;
	int n_compared = 0;
	int hi;
	int dv[4] = '{1, 2, 1, 1};
	int per[4] = '{161, 322, 177, 121};
	logic [15:0] lc[4] = '{16'h0003, 16'h0003, 16'h0007, 16'h0004};

	asp_uart DUT (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd),
		.rts_n(rts_n), .cts_n(cts_n), .dtr_n(dtr_n), .dsr_n(dsr_n), .irq(irq));
	asp_remote rem (.core_clk(core_clk), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n),
		.dsr_n(dsr_n));

	// ******************************
	// Clock, bus tasks and checks
	// ******************************
	// Clock of 100 ns period.
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken there.
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	task automatic rc(input logic [3:0] a, input logic [15:0] mk, input logic [15:0] e,
		input string n);
		rd(a);
		chk(n, v & mk, e);
	endtask

	task automatic pause(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Both waits are bounded, so a silent port shows up as a mismatch, not a hang.
	task automatic wait_tx(input int n);
		for (int w = 0; w < 8000 && rem.got_q.size() < n; w++) pause(1);
	endtask

	task automatic wait_rx();
		v = 16'h0000;
		for (int w = 0; w < 300 && v[0] !== 1'b1; w++) rd(4'h5);
	endtask

	// ******************************
	// Scenarios
	// ******************************
	// Runs every scenario in turn from one reset.
	initial begin
		reset = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		chk("pins", {12'h000, txd, rts_n, dtr_n, irq}, 16'h000e);
		rc(4'h3, 16'hffff, 16'h0003, "line ctrl");
		rc(4'h7, 16'hffff, 16'h0001, "divisor");
		rc(4'h2, 16'hffff, 16'h0001, "int id");
		rc(4'h6, 16'hffff, 16'h0003, "modem status");
		rc(4'hc, 16'hffff, 16'h0000, "unmapped");
		wr(4'h4, 16'h0003);
		pause(2);
		chk("rts dtr", {14'h0000, rts_n, dtr_n}, 16'h0000);
		// Character timing for divisors 1 and 2, lengths five and eight, and all three stop lengths; one idle tick between.
		for (int k = 0; k < 4; k++) begin
			wr(4'h7, 16'(dv[k]));
			wr(4'h3, lc[k]);
			rem.bitc = 16 * dv[k];
			rem.nbits = lc[k][1:0] + 5;
			rem.got_q.delete();
			rem.stamp_q.delete();
			wr(4'h0, 16'h0035);
			wr(4'h0, 16'h00ca);
			wait_tx(2);
			chk("period", 16'((rem.stamp_q[1] - rem.stamp_q[0]) / 100), 16'(per[k]));
			chk("tx char", 16'(rem.got_q[1]), 16'h00ca & ((16'h0001 << rem.nbits) - 1));
		end
		wr(4'h7, 16'h0001);
		rem.bitc = 16;
		// Lengths five to eight, no parity, odd and even, both directions.
		for (int k = 0; k < 4; k++) begin
			lcv = 16'(k) | (k[0] ? 16'h0008 : 16'h0000) | (k == 3 ? 16'h0010 : 16'h0000);
			wr(4'h3, lcv);
			rem.nbits = k + 5;
			rem.par_en = lcv[3];
			rem.even = lcv[4];
			rem.got_q.delete();
			rem.send(8'hb6, k + 5, lcv[3], lcv[4], 1'b0, 1'b0);
			wait_rx();
			rc(4'h0, 16'hffff, 16'h00b6 & ((16'h0001 << (k + 5)) - 1), "rx char");
			wr(4'h0, 16'h004d);
			wait_tx(1);
			chk("tx parity", 16'(rem.got_q[0]), 16'h004d & ((16'h0001 << (k + 5)) - 1));
		end
		// Parity error, framing error and break, with line status first in priority.
		wr(4'h1, 16'h0007);
		rem.send(8'hb6, 8, 1'b1, 1'b1, 1'b1, 1'b0);
		wait_rx();
		rc(4'h2, 16'hffff, 16'h0006, "int id rls");
		rc(4'h0, 16'hffff, 16'h01b6, "parity flag");
		rc(4'h8, 16'h0001, 16'h0001, "line status");
		rem.send(8'hb6, 8, 1'b1, 1'b1, 1'b0, 1'b1);
		wait_rx();
		rc(4'h0, 16'hffff, 16'h02b6, "frame flag");
		rem.brk(600);
		wait_rx();
		rc(4'h0, 16'h0400, 16'h0400, "break flag");
		// Shadow write of the modem lines, then soft reset.
		wr(4'h4, 16'h0000);
		wr(4'hb, 16'h0001);
		pause(2);
		chk("shadow dtr", 16'(dtr_n), 16'h0000);
		wr(4'ha, 16'h00a5);
		pause(2);
		rc(4'h3, 16'hffff, 16'h0003, "soft reset");
		rc(4'h5, 16'h0003, 16'h0002, "flushed");
		chk("soft pins", {14'h0000, rts_n, dtr_n}, 16'h0003);
		wr(4'h4, 16'h0003);
		rem.par_en = 1'b0;
		rem.nbits = 8;
		// Data-available over tx empty, masking and clearing.
		wr(4'h9, 16'h000f);
		wr(4'h1, 16'h0007);
		rem.got_q.delete();
		rem.send(8'h3c, 8, 1'b0, 1'b0, 1'b0, 1'b0);
		wr(4'h0, 16'h0011);
		wait_tx(1);
		pause(2);
		chk("irq", 16'(irq), 16'h0001);
		rc(4'h2, 16'hffff, 16'h0004, "int id rda");
		rc(4'h0, 16'hffff, 16'h003c, "rx byte");
		wr(4'h9, 16'h0002);
		rc(4'h2, 16'hffff, 16'h0002, "int id tx empty");
		wr(4'h1, 16'h0000);
		pause(2);
		chk("masked", 16'(irq), 16'h0000);
		wr(4'h9, 16'h0004);
		wr(4'h1, 16'h0007);
		rc(4'h2, 16'hffff, 16'h0001, "cleared");
		// Sixteen-deep transmit queue, then receive overrun.
		rem.got_q.delete();
		for (int k = 0; k < 17; k++) wr(4'h0, 16'(k + 64));
		rc(4'h5, 16'h0040, 16'h0040, "tx full");
		wait_tx(17);
		for (int k = 0; k < 17; k++) chk("tx order", 16'(rem.got_q[k]), 16'(k + 64));
		rem.ignore_rts = 1'b1;
		for (int k = 0; k < 17; k++) rem.send(8'(k + 128), 8, 1'b0, 1'b0, 1'b0, 1'b0);
		rem.ignore_rts = 1'b0;
		pause(40);
		rc(4'h5, 16'h0029, 16'h0029, "overrun");
		for (int k = 0; k < 16; k++) rc(4'h0, 16'hffff, 16'(k + 128), "rx order");
		rc(4'h5, 16'h0003, 16'h0002, "rx empty");
		// Automatic flow control holds a character while clear to send is withdrawn.
		wr(4'h4, 16'h0023);
		rem.cts_on = 1'b0;
		pause(4);
		rem.got_q.delete();
		wr(4'h0, 16'h0055);
		pause(400);
		chk("held", 16'(rem.got_q.size()), 16'h0000);
		rem.cts_on = 1'b1;
		wait_tx(1);
		chk("released", 16'(rem.got_q[0]), 16'h0055);
		// Transmit break, then infrared pulses in both pulse widths.
		rem.listen = 1'b0;
		wr(4'h4, 16'h0003);
		wr(4'h3, 16'h0043);
		pause(20);
		chk("tx break", 16'(txd), 16'h0000);
		wr(4'h3, 16'h0003);
		pause(20);
		chk("tx idle", 16'(txd), 16'h0001);
		for (int k = 0; k < 2; k++) begin
			wr(4'h4, k ? 16'h00c3 : 16'h0043);
			pause(20);
			chk("sir idle", 16'(txd), 16'h0000);
			wr(4'h0, 16'h0000);
			hi = 0;
			repeat (300) begin
				pause(1);
				hi = hi + (txd === 1'b1);
			end
			chk("sir pulses", 16'(hi), k ? 16'h0009 : 16'h001b);
		end
		wrap_up();
	end

	// Cuts a hang short well beyond the expected run of about 11000 cycles.
	initial begin
		repeat (40000) @(posedge core_clk);
		n_errors++;
		wrap_up();
	end
endmodule // async_serial_port_with_fifos_bench
